// file: segment_lcd_driver.sv
// Segment display controller: data words, alternating divider, common scan and pin drive
// Summary of operation
// - Drive 24 segment outputs and 4 common outputs, 96 dots total.
// - Drive scheme is one of five build-time bias and duty choices.
// - Alternating frequency is base clock divided by 64, 128, 256 or 512.
// - Frame rate equals alternating frequency divided by commons in use.
// - Hold 24 four-bit display words, first to last, one per segment.
// - Words reach segment outputs continuously by hardware, no software refresh.
// - Bit one gives the lit waveform, bit zero the unlit waveform.
// - Word n drives segment n; bits 0 to 3 select commons 0 to 3.
// - Display-on enables drive when DC_OUTPUT is clear; display-off disables it unless display-on lands in the same cycle.
// - All dots lit during reset; display off after reset until display-on.
// - In DC mode the drive-type register picks push-pull or open-drain.
// - In DC mode every fourth word drives four segment pins directly.
// - In DC mode the other words are plain data storage.
// - Drive-type register is 6 bits, write-only; bit k sets segments 4k..4k+3.
// - Drivable dots are 24, 48, 72 or 96 by commons in use.
module segment_lcd_driver
	import lcd_drv_pkg::*;
#(
	parameter drive_mode_t DRIVE_MODE = MODE_B3_D4, // Bias and duty option
	parameter alt_div_t    ALT_DIV    = ALT_DIV_512, // Alternating divider option
	parameter bit          DC_OUTPUT  = 1'b0         // Segment pins as DC port
) (
	input  wire logic                            clock_in,         // 100 MHz system clock
	input  wire logic                            rst_n_in,         // Async reset, active low
	input  wire logic                            base_tick_in,     // One pulse per display base clock period
	input  wire cpu_cmd_t                        cmd_in,           // Instruction side commands
	output logic [WORD_W-1:0]                    rd_data_out,      // Display word read data
	output logic [NUM_COMS-1:0][LEVEL_W-1:0]     com_level_out,    // Common drive level codes
	output logic [NUM_SEGS-1:0][LEVEL_W-1:0]     seg_level_out,    // Segment drive level codes
	output logic [NUM_SEGS-1:0]                  seg_dc_out,       // DC port output value
	output logic [NUM_SEGS-1:0]                  seg_dc_oe_out,    // DC port output enable
	output logic                                 display_on_out    // Display-on state; panel levels driven only when DC_OUTPUT is clear
);

	if (DRIVE_MODE > MODE_B3_D4) begin : g_bad_mode
		$error("Unsupported drive mode");
	end

	// Commons in use and bias per option
	localparam logic [2:0] NCOM = (DRIVE_MODE == MODE_STATIC) ? 3'h1 :
		(DRIVE_MODE == MODE_B2_D2) ? 3'h2 :
		(DRIVE_MODE == MODE_B3_D4) ? 3'h4 : 3'h3;
	localparam bit THIRD_BIAS = (DRIVE_MODE == MODE_B3_D3) || (DRIVE_MODE == MODE_B3_D4);
	localparam bit STATIC_MODE = (DRIVE_MODE == MODE_STATIC);
	localparam logic [1:0] LAST_COM = 2'(NCOM - 3'h1);
	localparam logic [ALT_CNT_W-1:0] ALT_TERM = ALT_CNT_W'((ALT_DIV_BASE << int'(ALT_DIV)) - 1);

	logic [WORD_W-1:0]                word_reg [NUM_SEGS];
	logic [WORD_W-1:0]                rd_data_reg;
	logic [DRIVE_TYPE_W-1:0]          drive_type_reg;
	logic                             on_reg;
	logic [ALT_CNT_W-1:0]             alt_cnt_reg;
	logic [1:0]                       com_idx_reg;
	logic                             pol_reg;
	logic [NUM_COMS-1:0][LEVEL_W-1:0] com_level_reg;
	logic [NUM_SEGS-1:0][LEVEL_W-1:0] seg_level_reg;
	logic [NUM_SEGS-1:0]              seg_dc_reg;
	logic [NUM_SEGS-1:0]              seg_dc_oe_reg;

	wire addr_ok   = cmd_in.word_addr <= LAST_DISPLAY_WORD;
	wire alt_tick  = base_tick_in && (alt_cnt_reg == ALT_TERM);
	wire frame_end = com_idx_reg == LAST_COM;
	wire drive_lcd = on_reg && !DC_OUTPUT;
	// Display-on wins when both commands land together
	wire on_next   = cmd_in.display_on_command ? 1'b1 :
		cmd_in.display_off_command ? 1'b0 : on_reg;

	// Static selects its one common at full swing; multiplexed non-select sits at V1, or at V1/V2 by polarity at third bias
	wire [LEVEL_W-1:0] com_sel_lvl   = pol_reg ? LVL_V3 : LVL_V0;
	wire [LEVEL_W-1:0] com_unsel_lvl = THIRD_BIAS ? (pol_reg ? LVL_V1 : LVL_V2) : LVL_V1;
	wire [LEVEL_W-1:0] seg_lit_lvl   = pol_reg ? LVL_V0 : LVL_V3;
	wire [LEVEL_W-1:0] seg_dark_lvl  = THIRD_BIAS ? (pol_reg ? LVL_V2 : LVL_V1) : com_sel_lvl;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NUM_SEGS; i++) begin
				word_reg[i] <= WORD_RESET;
			end
		end else if (cmd_in.word_wr && addr_ok) begin
			word_reg[cmd_in.word_addr] <= cmd_in.word_data;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_reg <= WORD_RESET;
		end else if (cmd_in.word_rd) begin
			rd_data_reg <= addr_ok ? word_reg[cmd_in.word_addr] : WORD_RESET;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drive_type_reg <= DRIVE_TYPE_RESET;
			on_reg         <= 1'b0;
		end else begin
			if (cmd_in.drive_type_wr) begin
				drive_type_reg <= cmd_in.drive_type_data;
			end
			on_reg <= on_next;
		end
	end

	// Alternating divider and common scan; frame = NCOM alternating periods
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			alt_cnt_reg <= '0;
			com_idx_reg <= 2'h0;
			pol_reg     <= 1'b1;
		end else if (base_tick_in) begin
			alt_cnt_reg <= alt_tick ? '0 : alt_cnt_reg + 1'b1;
			if (alt_tick) begin
				com_idx_reg <= frame_end ? 2'h0 : com_idx_reg + 2'h1;
				pol_reg     <= frame_end ? !pol_reg : pol_reg;
			end
		end
	end

	for (genvar c = 0; c < NUM_COMS; c++) begin : g_com
		wire in_use = c < int'(NCOM);
		wire [LEVEL_W-1:0] lvl_next = (!drive_lcd || !in_use) ? LVL_V0 :
			(STATIC_MODE || com_idx_reg == 2'(c)) ? com_sel_lvl : com_unsel_lvl;
		always_ff @(posedge clock_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				com_level_reg[c] <= LVL_V3;
			end else begin
				com_level_reg[c] <= lvl_next;
			end
		end
	end

	// Every segment reads its own word each cycle, so the panel never waits on software
	for (genvar s = 0; s < NUM_SEGS; s++) begin : g_seg
		wire dot = word_reg[s][com_idx_reg];
		wire [LEVEL_W-1:0] lvl_next = !drive_lcd ? LVL_V0 : (dot ? seg_lit_lvl : seg_dark_lvl);
		wire dc_bit = word_reg[(s / DC_GROUP) * DC_GROUP][s % DC_GROUP];
		wire od     = drive_type_reg[s / DC_GROUP];
		always_ff @(posedge clock_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				seg_level_reg[s] <= LVL_V0;
				seg_dc_reg[s]    <= 1'b0;
				seg_dc_oe_reg[s] <= 1'b0;
			end else begin
				seg_level_reg[s] <= lvl_next;
				seg_dc_reg[s]    <= DC_OUTPUT && !od && dc_bit;
				seg_dc_oe_reg[s] <= DC_OUTPUT && (!od || !dc_bit);
			end
		end
	end

	assign rd_data_out    = rd_data_reg;
	assign com_level_out  = com_level_reg;
	assign seg_level_out  = seg_level_reg;
	assign seg_dc_out     = seg_dc_reg;
	assign seg_dc_oe_out  = seg_dc_oe_reg;
	assign display_on_out = on_reg;

	a_on_command_enables: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		cmd_in.display_on_command |=> on_reg ##1 (on_reg || $past(cmd_in.display_off_command)))
		else $error("display-on command did not enable drive");

	a_off_command_disables: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		cmd_in.display_off_command && !cmd_in.display_on_command |=> !on_reg)
		else $error("display-off command did not disable drive");

	a_off_commons_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!on_reg |=> com_level_reg == '0 && seg_level_reg == '0)
		else $error("outputs not idle while display off");

	a_alt_divider_wrap: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		base_tick_in && alt_cnt_reg == ALT_TERM |=> alt_cnt_reg == '0)
		else $error("alternating divider did not wrap at its terminal count");

	a_scan_frame_order: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		alt_tick && frame_end |=> com_idx_reg == 2'h0 && pol_reg != $past(pol_reg))
		else $error("frame end did not restart scan with reversed polarity");

	a_scan_stays_in_use: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		1'b1 |-> com_idx_reg <= LAST_COM)
		else $error("scan reached an unused common");

	a_lit_dot_opposes: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		drive_lcd && !cmd_in.display_off_command && word_reg[0][com_idx_reg] && com_idx_reg == 2'h0
		|=> seg_level_reg[0] != com_level_reg[0])
		else $error("lit dot does not oppose its selected common");

	a_dc_push_pull: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		DC_OUTPUT && !drive_type_reg[0] |=> seg_dc_oe_reg[0] && seg_dc_reg[1] == $past(word_reg[0][1]))
		else $error("push-pull group not driving word bit");

	a_dc_open_drain: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		DC_OUTPUT && drive_type_reg[5] && word_reg[20][3] && !cmd_in.drive_type_wr |=> !seg_dc_oe_reg[23])
		else $error("open-drain pin pulled low for a one bit");

	a_word_read_back: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		cmd_in.word_rd && cmd_in.word_addr == 5'h01 |=> rd_data_reg == $past(word_reg[1]))
		else $error("read did not return stored word");

	a_word_write_lands: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		cmd_in.word_wr && cmd_in.word_addr == LAST_DISPLAY_WORD |=> word_reg[NUM_SEGS-1] == $past(cmd_in.word_data))
		else $error("write to the last display word did not land");

	a_high_addr_ignored: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		cmd_in.word_rd && !addr_ok |=> rd_data_reg == WORD_RESET)
		else $error("read beyond the last display word returned data");

	a_drive_type_load: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		cmd_in.drive_type_wr |=> drive_type_reg == $past(cmd_in.drive_type_data))
		else $error("drive-type write did not load");

	a_scan_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!alt_tick |=> com_idx_reg == $past(com_idx_reg) && pol_reg == $past(pol_reg))
		else $error("scan moved between alternating ticks");

	a_static_flip: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		STATIC_MODE && alt_tick |=> pol_reg != $past(pol_reg))
		else $error("static drive did not reverse polarity");

	a_dc_levels_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		DC_OUTPUT |=> com_level_reg == '0 && seg_level_reg == '0)
		else $error("panel levels driven in DC output mode");

endmodule : segment_lcd_driver

// file: lcd_drv_pkg.sv
// Shared constants, types and the CPU command carrier for the segment display driver
package lcd_drv_pkg;
	localparam int NUM_SEGS     = 24;
	localparam int NUM_COMS     = 4;
	localparam int WORD_W       = 4;
	localparam int ADDR_W       = 5;
	localparam int DRIVE_TYPE_W = 6;
	localparam int LEVEL_W      = 2;
	localparam int DC_GROUP     = 4;
	localparam int ALT_DIV_BASE = 64;
	localparam int ALT_CNT_W    = 9;

	localparam logic [ADDR_W-1:0]       FIRST_DISPLAY_WORD = 5'h00;
	localparam logic [ADDR_W-1:0]       LAST_DISPLAY_WORD  = 5'h17;
	localparam logic [WORD_W-1:0]       WORD_RESET         = 4'h0;
	localparam logic [DRIVE_TYPE_W-1:0] DRIVE_TYPE_RESET   = 6'h00;

	// Drive level codes, ground up to full panel voltage
	localparam logic [LEVEL_W-1:0] LVL_V0 = 2'h0;
	localparam logic [LEVEL_W-1:0] LVL_V1 = 2'h1;
	localparam logic [LEVEL_W-1:0] LVL_V2 = 2'h2;
	localparam logic [LEVEL_W-1:0] LVL_V3 = 2'h3;

	typedef enum logic [2:0] {
		MODE_STATIC = 3'b000,
		MODE_B2_D2  = 3'b001,
		MODE_B2_D3  = 3'b010,
		MODE_B3_D3  = 3'b011,
		MODE_B3_D4  = 3'b100
	} drive_mode_t;

	typedef enum logic [1:0] {
		ALT_DIV_64  = 2'b00,
		ALT_DIV_128 = 2'b01,
		ALT_DIV_256 = 2'b10,
		ALT_DIV_512 = 2'b11
	} alt_div_t;

	typedef struct packed {
		logic                    word_wr;
		logic                    word_rd;
		logic [ADDR_W-1:0]       word_addr;
		logic [WORD_W-1:0]       word_data;
		logic                    display_on_command;
		logic                    display_off_command;
		logic                    drive_type_wr;
		logic [DRIVE_TYPE_W-1:0] drive_type_data;
	} cpu_cmd_t;
endpackage : lcd_drv_pkg

// file: lcd_panel_model.sv
// Passive glass model: a dot shows while the full panel voltage sits across it
module lcd_panel_model
	import lcd_drv_pkg::*;
(
	input  wire logic [NUM_COMS-1:0][LEVEL_W-1:0] com_in,  // Common levels
	input  wire logic [NUM_SEGS-1:0][LEVEL_W-1:0] seg_in,  // Segment levels
	output logic      [NUM_SEGS-1:0][NUM_COMS-1:0] dot_out // Dots at full voltage
);
	timeunit 1ns;
	timeprecision 1ps;
	// Partial bias voltages never reach the threshold, so only rail to rail counts
	always_comb begin
		for (int s = 0; s < NUM_SEGS; s++) begin
			for (int c = 0; c < NUM_COMS; c++) begin
				dot_out[s][c] = (com_in[c] == LVL_V3 && seg_in[s] == LVL_V0) ||
					(com_in[c] == LVL_V0 && seg_in[s] == LVL_V3);
			end
		end
	end
endmodule : lcd_panel_model

// file: tb.sv
// Self-checking bench for the segment display driver and its DC port option
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lcd_drv_pkg::*;
	logic                 clk, rst_n, tick, on, hi, lo, on_dc, gap_ok, un_st;
	cpu_cmd_t             cmd;
	logic [3:0]           rd, rd_dc;
	logic [3:0][1:0]      com, prev, com_dc, com_st;
	logic [23:0][1:0]     seg, seg_dc, seg_st;
	logic [23:0]          dc, oe, ed, eo, dc_lcd, oe_lcd, st, got_st;
	logic [23:0][3:0]     dots, acc, exp, dots_st, acc_st;
	int                   failures, checked, ch, last;
	segment_lcd_driver #(.ALT_DIV(ALT_DIV_64)) u_dut (.clock_in(clk), .rst_n_in(rst_n),
		.base_tick_in(tick), .cmd_in(cmd), .rd_data_out(rd), .com_level_out(com),
		.seg_level_out(seg), .seg_dc_out(dc_lcd), .seg_dc_oe_out(oe_lcd), .display_on_out(on));
	segment_lcd_driver #(.DC_OUTPUT(1'b1)) u_dc (.clock_in(clk), .rst_n_in(rst_n),
		.base_tick_in(tick), .cmd_in(cmd), .rd_data_out(rd_dc), .com_level_out(com_dc),
		.seg_level_out(seg_dc), .seg_dc_out(dc), .seg_dc_oe_out(oe), .display_on_out(on_dc));
	segment_lcd_driver #(.DRIVE_MODE(MODE_STATIC), .ALT_DIV(ALT_DIV_64)) u_static (.clock_in(clk),
		.rst_n_in(rst_n), .base_tick_in(tick), .cmd_in(cmd), .rd_data_out(), .com_level_out(com_st),
		.seg_level_out(seg_st), .seg_dc_out(), .seg_dc_oe_out(), .display_on_out());
	lcd_panel_model u_panel (.com_in(com), .seg_in(seg), .dot_out(dots));
	lcd_panel_model u_panel_st (.com_in(com_st), .seg_in(seg_st), .dot_out(dots_st));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) tick <= ~tick;
	function automatic logic [3:0] pat(int s);
		return 4'(s * 7 + 3);
	endfunction : pat
	task automatic chk(string what, logic [95:0] e, logic [95:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic send(cpu_cmd_t c);
		@(posedge clk) cmd <= c;
		@(posedge clk) cmd <= '0;
	endtask : send
	task automatic wr(logic [4:0] a, logic [3:0] d);
		send('{word_wr: 1'b1, word_addr: a, word_data: d, default: '0});
	endtask : wr
	task automatic rd_chk(logic [4:0] a, logic [3:0] e);
		send('{word_rd: 1'b1, word_addr: a, default: '0});
		#1 chk("read data", 96'({e, e}), 96'({rd, rd_dc}));
	endtask : rd_chk
	task automatic chk_dark();
		repeat (2) @(posedge clk);
		#1 chk("idle levels", 96'(0), 96'({on, com, seg}));
	endtask : chk_dark
	task automatic chk_lit();
		#1 chk("lit in reset", '1, dots);
		chk("off in reset", 96'(0), 96'(on));
	endtask : chk_lit
	task automatic test_words();
		for (int s = 0; s < NUM_SEGS; s++) wr(5'(s), pat(s));
		wr(5'h18, 4'hF);
		rd_chk(5'h17, pat(23));
		rd_chk(5'h18, 4'h0);
	endtask : test_words
	task automatic test_scan();
		send('{display_on_command: 1'b1, default: '0});
		{acc, acc_st, hi, lo, un_st, ch, last} = '0;
		gap_ok = 1'b1;
		prev = com;
		// Base tick comes every second clock, so a period is twice the divider
		for (int i = 0; i < 1100; i++) begin
			@(posedge clk);
			#1 acc |= dots;
			acc_st |= dots_st;
			un_st |= |com_st[3:1];
			hi |= com[0] === LVL_V3;
			lo |= com[0] === LVL_V0;
			if (com !== prev) begin
				if (ch >= 2) gap_ok &= (i - last) == 2 * ALT_DIV_BASE;
				last = i;
				ch++;
			end
			prev = com;
		end
		for (int s = 0; s < NUM_SEGS; s++) begin
			exp[s] = pat(s);
			st[s] = exp[s][0];
			got_st[s] = acc_st[s][0];
		end
		chk("dot map", exp, acc);
		chk("static dots", 96'(st), 96'(got_st));
		chk("static unused commons", 96'(0), 96'(un_st));
		chk("both polarities", 96'(2'b11), 96'({hi, lo}));
		chk("alternating rate", 96'(1), 96'(ch inside {[8:10]}));
		chk("alternating period", 96'(1), 96'(gap_ok));
		chk("display on", 96'(2'b11), 96'({on, on_dc}));
		chk("dc port unused", 96'(0), 96'({dc_lcd, oe_lcd}));
		chk("dc mode levels", 96'(0), 96'({com_dc, seg_dc}));
	endtask : test_scan
	task automatic test_dc();
		send('{drive_type_wr: 1'b1, drive_type_data: 6'h22, default: '0});
		wr(5'h00, 4'hA);
		wr(5'h04, 4'h5);
		wr(5'h01, 4'hC);
		rd_chk(5'h01, 4'hC);
		for (int g = 0; g < 6; g++) begin
			exp[g] = (g == 0) ? 4'hA : (g == 1) ? 4'h5 : pat(4 * g);
			ed[4*g+:4] = (g == 1 || g == 5) ? 4'h0 : exp[g];
			eo[4*g+:4] = (g == 1 || g == 5) ? ~exp[g] : 4'hF;
		end
		chk("dc pins", 96'({ed, eo}), 96'({dc, oe}));
	endtask : test_dc
	task automatic test_reset();
		send('{display_on_command: 1'b1, default: '0});
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk);
		chk_lit();
		@(posedge clk) rst_n <= 1'b1;
		chk_dark();
	endtask : test_reset
	task automatic finish_test();
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	initial begin
		{rst_n, tick, failures, checked} = '0;
		cmd = '0;
		repeat (20) @(posedge clk);
		chk_lit();
		@(posedge clk) rst_n <= 1'b1;
		chk_dark();
		test_words();
		test_scan();
		send('{display_off_command: 1'b1, default: '0});
		chk_dark();
		test_dc();
		test_reset();
		finish_test();
	end
	initial begin
		#50000;
		failures++;
		finish_test();
	end
endmodule : tb
